// ---- src/acc_top.sv ----
`timescale 1ns/1ps
`include "acc_cfg.svh"
`default_nettype none
// Contract
// - Plus below minus gives low output
// - Plus above minus gives high output
// - Disabled comparator feeds zero before the polarity bit is applied
// - Latches clocked by phases one, three
// - Sleep holds phase one active
// - Enable bit turns comparator on
// - Cleared enable powers comparator down
// - Two-bit field selects inverting pin
// - Own control registers plus aux register
// - Tracking latch samples every phase one
// - Reference latch samples on the first phase three at or after a register access
// - Flag set on mismatch rising edge
// - Polarity bit inverts reported output
module acc_top
  import acc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_mode,
  input wire logic comp1_raw,
  input wire logic comp2_raw,
  output logic comp1_power_on,
  output logic comp2_power_on,
  output logic [1:0] comp1_inv_sel,
  output logic [1:0] comp2_inv_sel,
  output logic comp1_ref_sel,
  output logic comp2_ref_sel,
  output logic comp1_speed,
  output logic comp2_speed,
  output logic comp1_pin_out,
  output logic comp2_pin_out,
  output logic comp1_pin_oe,
  output logic comp2_pin_oe,
  output logic timer_gate_sync,
  output logic irq
);
  // ***************************************
  // Registers and state
  // ***************************************
  acc_byte_t first_comp_control_reg;
  acc_byte_t second_comp_control_reg;
  acc_byte_t second_comp_aux_reg;
  logic [`ACC_IRQ_W-1:0] irq_status;
  logic [`ACC_IRQ_W-1:0] irq_mask;
  acc_phase_t phase;
  logic sync_out1;
  logic sync_out2;
  logic [31:0] rdata_q;
  acc_byte_t next_first_comp_control_reg;
  acc_byte_t next_second_comp_control_reg;
  acc_byte_t next_second_comp_aux_reg;
  logic [`ACC_IRQ_W-1:0] next_irq_status;
  logic [`ACC_IRQ_W-1:0] next_irq_mask;
  acc_phase_t next_phase;
  logic next_sync_out1;
  logic next_sync_out2;
  logic [31:0] next_rdata_q;
  logic raw1_s;
  logic raw2_s;
  logic out1;
  logic out2;
  logic phase_one;
  logic phase_three;
  logic acc1;
  logic acc2;
  logic ev1;
  logic ev2;
  logic trk1;
  logic trk2;
  logic apb_setup;
  logic apb_wr;
  logic addr_ok;

  // Comparator output after enable gating and polarity
  function automatic logic comp_out(input logic raw, input acc_byte_t ctrl);
    logic v;
    v = ctrl[`ACC_BIT_EN] ? raw : 1'b0;
    comp_out = v ^ ctrl[`ACC_BIT_POL];
  endfunction

  // Register write with writable-bit mask
  function automatic acc_byte_t ctrl_write(input acc_byte_t old, input logic [31:0] wd);
    ctrl_write = (old & ~`ACC_CTRL_WMASK) | (wd[7:0] & `ACC_CTRL_WMASK);
  endfunction

  // Control read-back with live output bit
  function automatic logic [31:0] ctrl_read(input acc_byte_t ctrl, input logic out);
    logic [31:0] r;
    r = {24'h00_0000, ctrl};
    r[`ACC_BIT_OUT] = out;
    ctrl_read = r;
  endfunction

  // ***************************************
  // Input synchronisers
  // ***************************************
  acc_sync u_sync1 (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(comp1_raw),
    .sync_out(raw1_s)
  );
  acc_sync u_sync2 (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(comp2_raw),
    .sync_out(raw2_s)
  );

  assign out1 = comp_out(raw1_s, first_comp_control_reg);
  assign out2 = comp_out(raw2_s, second_comp_control_reg);

  // ***************************************
  // Four-phase clock
  // ***************************************
  always_comb begin
    case (phase)
      acc_ph_one: begin
        next_phase = acc_ph_two;
      end
      acc_ph_two: begin
        next_phase = acc_ph_three;
      end
      acc_ph_three: begin
        next_phase = acc_ph_four;
      end
      acc_ph_four: begin
        next_phase = acc_ph_one;
      end
      default: begin
        next_phase = acc_ph_one;
      end
    endcase
  end
  // Sleep holds phase one high
  assign phase_one = (phase == acc_ph_one) | sleep_mode;
  assign phase_three = (phase == acc_ph_three);

  // ***************************************
  // APB decode
  // ***************************************
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite;
  assign addr_ok = (paddr == `ACC_OFF_CTRL1) | (paddr == `ACC_OFF_CTRL2) | (paddr == `ACC_OFF_AUX) |
                   (paddr == `ACC_OFF_STAT) | (paddr == `ACC_OFF_MASK);
  assign pready = 1'b1;
  // Unmapped offsets answer with an error
  assign pslverr = psel & penable & ~addr_ok;
  // Any control access queues a reference reload
  assign acc1 = psel & penable & (paddr == `ACC_OFF_CTRL1);
  assign acc2 = psel & penable & (paddr == `ACC_OFF_CTRL2);

  // ***************************************
  // Change detectors
  // ***************************************
  acc_mismatch u_mm1 (
    .pclk(pclk),
    .presetn(presetn),
    .phase_one(phase_one),
    .phase_three(phase_three),
    .reg_access(acc1),
    .comp_in(out1),
    .change_event(ev1),
    .tracked(trk1)
  );
  acc_mismatch u_mm2 (
    .pclk(pclk),
    .presetn(presetn),
    .phase_one(phase_one),
    .phase_three(phase_three),
    .reg_access(acc2),
    .comp_in(out2),
    .change_event(ev2),
    .tracked(trk2)
  );

  // ***************************************
  // Register file
  // ***************************************
  always_comb begin
    next_first_comp_control_reg = first_comp_control_reg;
    next_second_comp_control_reg = second_comp_control_reg;
    next_second_comp_aux_reg = second_comp_aux_reg;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    next_sync_out1 = phase_one ? out1 : sync_out1;
    next_sync_out2 = phase_one ? out2 : sync_out2;
    if (apb_wr) begin
      case (paddr)
        `ACC_OFF_CTRL1: begin
          next_first_comp_control_reg = ctrl_write(first_comp_control_reg, pwdata);
        end
        `ACC_OFF_CTRL2: begin
          next_second_comp_control_reg = ctrl_write(second_comp_control_reg, pwdata);
        end
        `ACC_OFF_AUX: begin
          next_second_comp_aux_reg = pwdata[7:0] & `ACC_AUX_WMASK;
        end
        `ACC_OFF_STAT: begin
          next_irq_status = irq_status & ~pwdata[`ACC_IRQ_W-1:0];
        end
        `ACC_OFF_MASK: begin
          next_irq_mask = pwdata[`ACC_IRQ_W-1:0];
        end
        default: begin
          next_irq_mask = irq_mask;
        end
      endcase
    end
    // Set wins over clear
    if (ev1) begin
      next_irq_status[`ACC_FLAG1] = 1'b1;
    end
    if (ev2) begin
      next_irq_status[`ACC_FLAG2] = 1'b1;
    end
    next_rdata_q = rdata_q;
    if (apb_setup && !pwrite) begin
      case (paddr)
        `ACC_OFF_CTRL1: begin
          next_rdata_q = ctrl_read(first_comp_control_reg, out1);
        end
        `ACC_OFF_CTRL2: begin
          next_rdata_q = ctrl_read(second_comp_control_reg, out2);
        end
        `ACC_OFF_AUX: begin
          next_rdata_q = {24'h00_0000, second_comp_aux_reg};
          next_rdata_q[`ACC_AUX_OUT1] = trk1;
          next_rdata_q[`ACC_AUX_OUT2] = trk2;
        end
        `ACC_OFF_STAT: begin
          next_rdata_q = {30'h0000_0000, irq_status};
        end
        `ACC_OFF_MASK: begin
          next_rdata_q = {30'h0000_0000, irq_mask};
        end
        default: begin
          next_rdata_q = `ACC_ZERO32;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_comp_control_reg <= `ACC_CTRL_RST;
      second_comp_control_reg <= `ACC_CTRL_RST;
      second_comp_aux_reg <= `ACC_AUX_RST;
      irq_status <= `ACC_IRQ_RST;
      irq_mask <= `ACC_IRQ_RST;
      phase <= acc_ph_one;
      sync_out1 <= 1'b0;
      sync_out2 <= 1'b0;
      rdata_q <= `ACC_ZERO32;
    end else begin
      first_comp_control_reg <= next_first_comp_control_reg;
      second_comp_control_reg <= next_second_comp_control_reg;
      second_comp_aux_reg <= next_second_comp_aux_reg;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      phase <= next_phase;
      sync_out1 <= next_sync_out1;
      sync_out2 <= next_sync_out2;
      rdata_q <= next_rdata_q;
    end
  end

  // ***************************************
  // Outputs
  // ***************************************
  assign prdata = rdata_q;
  assign comp1_power_on = first_comp_control_reg[`ACC_BIT_EN];
  assign comp2_power_on = second_comp_control_reg[`ACC_BIT_EN];
  assign comp1_inv_sel = first_comp_control_reg[`ACC_SEL_HI:`ACC_SEL_LO];
  assign comp2_inv_sel = second_comp_control_reg[`ACC_SEL_HI:`ACC_SEL_LO];
  assign comp1_ref_sel = first_comp_control_reg[`ACC_BIT_REFSEL];
  assign comp2_ref_sel = second_comp_control_reg[`ACC_BIT_REFSEL];
  assign comp1_speed = first_comp_control_reg[`ACC_BIT_SP];
  assign comp2_speed = second_comp_control_reg[`ACC_BIT_SP];
  assign comp1_pin_out = trk1;
  assign comp2_pin_out = trk2;
  assign comp1_pin_oe = first_comp_control_reg[`ACC_BIT_OE] & first_comp_control_reg[`ACC_BIT_EN];
  assign comp2_pin_oe = second_comp_control_reg[`ACC_BIT_OE] & second_comp_control_reg[`ACC_BIT_EN];
  // Timer gate source picked by aux select bits
  assign timer_gate_sync = (second_comp_aux_reg[`ACC_AUX_SYNC1] & sync_out1) |
                           (second_comp_aux_reg[`ACC_AUX_SYNC2] & sync_out2);
  assign irq = |(irq_status & irq_mask);
endmodule
`default_nettype wire

// ---- inc/acc_cfg.svh ----
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH
// Register byte offsets
`define ACC_OFF_CTRL1 12'h000
`define ACC_OFF_CTRL2 12'h004
`define ACC_OFF_AUX 12'h008
`define ACC_OFF_STAT 12'h00C
`define ACC_OFF_MASK 12'h010
// Control register fields
`define ACC_BIT_EN 7
`define ACC_BIT_OUT 6
`define ACC_BIT_OE 5
`define ACC_BIT_POL 4
`define ACC_BIT_SP 3
`define ACC_BIT_REFSEL 2
`define ACC_SEL_HI 1
`define ACC_SEL_LO 0
`define ACC_CTRL_RST 8'h08
`define ACC_CTRL_WMASK 8'hBF
// Aux register fields
`define ACC_AUX_OUT1 7
`define ACC_AUX_OUT2 6
`define ACC_AUX_SYNC1 1
`define ACC_AUX_SYNC2 0
`define ACC_AUX_WMASK 8'h03
`define ACC_AUX_RST 8'h00
// Status and mask fields
`define ACC_FLAG1 0
`define ACC_FLAG2 1
`define ACC_IRQ_W 2
`define ACC_IRQ_RST 2'h0
`define ACC_ZERO32 32'h0000_0000
`endif

// ---- inc/acc_pkg.sv ----
package acc_pkg;
  typedef logic [7:0] acc_byte_t;
  typedef enum logic [1:0] {
    acc_ph_one = 2'h0,
    acc_ph_two = 2'h1,
    acc_ph_three = 2'h3,
    acc_ph_four = 2'h2
  } acc_phase_t;
endpackage

// ---- src/acc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// ***************************************
// Two-stage synchroniser
// ***************************************
module acc_sync
  import acc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// ---- src/acc_mismatch.sv ----
`timescale 1ns/1ps
`include "acc_cfg.svh"
`default_nettype none
// ***************************************
// Change detector: two latches and XOR
// ***************************************
module acc_mismatch
  import acc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic phase_one,
  input wire logic phase_three,
  input wire logic reg_access,
  input wire logic comp_in,
  output logic change_event,
  output logic tracked
);
  logic ref_latch;
  logic track_latch;
  logic mismatch_d;
  logic next_ref_latch;
  logic next_track_latch;
  logic next_mismatch_d;
  logic pend_access;
  logic next_pend_access;
  logic mismatch;
  assign mismatch = ref_latch ^ track_latch;
  always_comb begin
    next_track_latch = phase_one ? comp_in : track_latch;
    next_pend_access = pend_access | reg_access;
    next_ref_latch = ref_latch;
    if (phase_three && next_pend_access) begin
      next_ref_latch = comp_in;
      next_pend_access = 1'b0;
    end
    next_mismatch_d = mismatch;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_latch <= 1'b0;
      track_latch <= 1'b0;
      mismatch_d <= 1'b0;
      pend_access <= 1'b0;
    end else begin
      ref_latch <= next_ref_latch;
      track_latch <= next_track_latch;
      mismatch_d <= next_mismatch_d;
      pend_access <= next_pend_access;
    end
  end
  assign change_event = mismatch & ~mismatch_d;
  assign tracked = track_latch;
endmodule
`default_nettype wire

// ---- bench/acc_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********
// Port checks
// ********
module acc_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_mode,
  input wire logic comp1_power_on,
  input wire logic comp2_power_on,
  input wire logic [1:0] comp1_inv_sel,
  input wire logic [1:0] comp2_inv_sel,
  input wire logic comp1_pin_out,
  input wire logic comp1_pin_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr1;
  logic wr2;
  assign wr1 = psel && penable && pwrite && paddr == 12'h0;
  assign wr2 = psel && penable && pwrite && paddr == 12'h4;
  property p_off;
    $rose(presetn) |-> !comp1_power_on && !comp2_power_on;
  endproperty
  a_off: assert property (p_off) else $error("on after reset");
  property p_en1;
    wr1 |=> comp1_power_on == $past(pwdata[7]);
  endproperty
  a_en1: assert property (p_en1) else $error("enable one");
  property p_en2;
    wr2 |=> comp2_power_on == $past(pwdata[7]);
  endproperty
  a_en2: assert property (p_en2) else $error("enable two");
  property p_sel;
    wr1 |=> comp1_inv_sel == $past(pwdata[1:0]);
  endproperty
  a_sel: assert property (p_sel) else $error("select one");
  property p_hold;
    !wr2 |=> $stable(comp2_inv_sel);
  endproperty
  a_hold: assert property (p_hold) else $error("select two moved");
  property p_oe;
    comp1_pin_oe |-> comp1_power_on;
  endproperty
  a_oe: assert property (p_oe) else $error("drive while off");
  property p_track;
    $changed(comp1_pin_out) && !$past(sleep_mode) |=> (!$changed(comp1_pin_out) || $past(sleep_mode))[*3];
  endproperty
  a_track: assert property (p_track) else $error("track off phase");
  property p_err;
    psel && penable |-> pready && pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010});
  endproperty
  a_err: assert property (p_err) else $error("bus answer");
endmodule
bind acc_top acc_chk acc_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .sleep_mode, .comp1_power_on, .comp2_power_on, .comp1_inv_sel, .comp2_inv_sel,
  .comp1_pin_out, .comp1_pin_oe);
`default_nettype wire

// ---- bench/acc_analog.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********
// Analog inputs
// ********
module acc_analog (
  input wire logic pclk,
  input wire logic [1:0] sel1,
  input wire logic [1:0] sel2,
  input wire logic on1,
  input wire logic on2,
  output logic raw1,
  output logic raw2
);
  int vp [2];
  int vm [2][4];
  initial begin
    raw1 = 1'h0;
    raw2 = 1'h0;
  end
  // Powered-down output wanders
  always @(posedge pclk) begin
    raw1 <= on1 ? vp[0] > vm[0][sel1] : !raw1;
    raw2 <= on2 ? vp[1] > vm[1][sel2] : !raw2;
  end
endmodule
`default_nettype wire

// ---- bench/test_analog_comparator_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_analog_comparator_control;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic sleep_mode = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] st = 32'h1d09;
  logic [31:0] prdata, rd, d, q;
  logic pready, pslverr, comp1_raw, comp2_raw, comp1_power_on, comp2_power_on, comp1_pin_out, irq;
  logic [1:0] comp1_inv_sel, comp2_inv_sel;
  logic comp1_ref_sel, comp2_ref_sel, comp1_speed, comp2_speed, comp2_pin_out, comp1_pin_oe, comp2_pin_oe;
  logic timer_gate_sync;
  logic [2:0] pins1, pins2;
  int ctl [2];
  int n_fail = 0;
  int checked = 0;
  int msk = 0;
  int v, m, o;
  always #4 pclk = ~pclk;
  assign pins1 = {comp1_ref_sel, comp1_speed, comp1_pin_oe};
  assign pins2 = {comp2_ref_sel, comp2_speed, comp2_pin_oe};
  acc_top acc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sleep_mode, .comp1_raw, .comp2_raw, .comp1_power_on, .comp2_power_on, .comp1_inv_sel,
    .comp2_inv_sel, .comp1_ref_sel, .comp2_ref_sel, .comp1_speed, .comp2_speed, .comp1_pin_out,
    .comp2_pin_out, .comp1_pin_oe, .comp2_pin_oe, .timer_gate_sync, .irq);
  acc_analog acc_analog_inst (.pclk, .sel1(comp1_inv_sel), .sel2(comp2_inv_sel), .on1(comp1_power_on),
    .on2(comp2_power_on), .raw1(comp1_raw), .raw2(comp2_raw));
  function automatic logic [31:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction
  task automatic wrap_up();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_pin(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected pin at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task sv(input int c, input int s, input int a, input int b);
    acc_analog_inst.vp[c] <= a;
    acc_analog_inst.vm[c][s] <= b;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] x);
    int k;
    k = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= x;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (k == 20) begin
      n_fail++;
      wrap_up();
    end
    if (w && a < 12'h008) begin
      ctl[a[2]] = int'(x & 32'h0000_00bf);
    end
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic flag(input int b, input logic [31:0] e);
    sv(0, 0, 2, b);
    repeat (10) @(posedge pclk);
    bus(1'h0, 12'hc, 32'h0);
    chk(e, rd);
    chk_pin(32'((e & msk) != 0), {31'h0, irq});
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      bus(1'h0, 12'(i * 4), 32'h0);
      chk(i < 2 ? 32'h8 : 32'h0, rd);
    end
    bus(1'h0, 12'h2, 32'h0);
    chk(32'h0, rd);
    for (int i = 0; i < 16; i++) begin
      v = 2 * int'(rnd() % 500);
      m = 2 * int'(rnd() % 500) + 1;
      o = int'(v > m) ^ (i / 8);
      sv(i % 2, i / 2 % 4, v, m);
      d = rnd() & 32'hffff_ff64 | 32'h88 | 32'(i / 8 * 16 + i / 2 % 4);
      bus(1'h1, 12'(i % 2 * 4), d);
      repeat (10) @(posedge pclk);
      bus(1'h0, 12'(i % 2 * 4), 32'h0);
      chk(32'(ctl[i % 2]) | 32'(o * 64), rd);
      q = 32'(ctl[i % 2]);
      chk_pin({29'h0, q[2], q[3], q[5] & q[7]}, {29'h0, (i % 2 ? pins2 : pins1)});
    end
    bus(1'h1, 12'h4, 32'h8);
    sv(0, 0, 2, 1);
    bus(1'h1, 12'h0, 32'h80);
    repeat (10) @(posedge pclk);
    bus(1'h0, 12'h0, 32'h0);
    bus(1'h1, 12'hc, 32'h3);
    msk = 1;
    bus(1'h1, 12'h10, 32'h1);
    flag(3, 32'h1);
    bus(1'h1, 12'hc, 32'h1);
    flag(3, 32'h0);
    flag(1, 32'h0);
    flag(3, 32'h1);
    bus(1'h1, 12'hc, 32'h1);
    bus(1'h0, 12'h0, 32'h0);
    msk = 0;
    bus(1'h1, 12'h10, 32'h0);
    flag(1, 32'h1);
    bus(1'h1, 12'h0, 32'h18);
    repeat (10) @(posedge pclk);
    bus(1'h1, 12'hc, 32'h3);
    flag(2, 32'h0);
    bus(1'h0, 12'h0, 32'h0);
    chk(32'h58, rd);
    sleep_mode <= 1'h1;
    bus(1'h1, 12'h0, 32'h80);
    repeat (10) @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      sv(0, 0, 2, 1 + 2 * (i % 2));
      repeat (4) @(posedge pclk);
      #1;
      chk_pin(32'(1 - i % 2), {31'h0, comp1_pin_out});
      @(posedge pclk);
    end
    sleep_mode <= 1'h0;
    bus(1'h1, 12'h8, 32'h2);
    sv(0, 0, 2, 1);
    repeat (10) @(posedge pclk);
    bus(1'h0, 12'h8, 32'h0);
    chk(32'h82, rd);
    chk_pin(32'h6, {29'h0, timer_gate_sync, comp1_pin_out, comp2_pin_out});
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    bus(1'h0, 12'h0, 32'h0);
    chk(32'h8, rd);
    chk_pin(32'h0, {28'h0, comp1_power_on, comp2_power_on, comp1_pin_oe, timer_gate_sync});
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
